// *** logic/lasi_defs.svh ***
// Register map, field positions, thresholds and timing constants of the line alarm status block.
`ifndef LASI_DEFS_SVH
`define LASI_DEFS_SVH
`define LASI_ADDR_STATUS 8'h06
`define LASI_ADDR_MASK 8'h07
`define LASI_READ_NONE 8'h00
`define LASI_MASK_RESET 8'h00
`define LASI_STATUS_RESET 8'h00
`define LASI_LATCHED_BITS 8'hD8
`define LASI_CHANGE_BITS 8'h38
`define LASI_BIT_TXCLK 5
`define LASI_BIT_UA1 4
`define LASI_BIT_RCL 3
`define LASI_CLK_MHZ 250
`define LASI_TXCLK_LOSS_NS 5000
`define LASI_T1_WINDOW_US 3000
`define LASI_E1_UA1_SPAN 12'h200
`define LASI_E1_UA1_ZEROS 12'h002
`define LASI_T1_UA1_SET_MAX 12'h005
`define LASI_E1_RCL_SHORT 12'h0FF
`define LASI_E1_RCL_LONG 12'h800
`define LASI_E1_RCL_SPAN 12'h0FF
`define LASI_E1_RCL_ONES 12'h020
`define LASI_T1_RCL_SHORT 12'h0C0
`define LASI_T1_RCL_LONG 12'h608
`define LASI_T1_RCL_SPAN 12'h070
`define LASI_T1_RCL_ONES 12'h00E
`endif

// *** logic/lasi_pkg.sv ***
// Shared types of the line alarm status block.
package lasi_pkg;
    typedef logic [7:0] lasi_byte_t;
    typedef logic [11:0] lasi_count_t;
    typedef enum logic {LASI_E1, LASI_T1} lasi_mode_t;
endpackage : lasi_pkg

// *** logic/lasi_pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module lasi_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [WIDTH-1:0] s1_next, s2_next, s3_next, out_next;
    logic [WIDTH-1:0] agree;

    always_comb
    begin
        s1_next = pinIn;
        s2_next = s1_reg;
        s3_next = s2_reg;
        agree = ~(s2_reg ^ s3_reg);
        out_next = (agree & s3_reg) | (~agree & out_reg);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end
        else
        begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            out_reg <= out_next;
        end
    end

    assign pinOut = out_reg;
endmodule : lasi_pin_sync

// *** logic/lasi_clock_watch.sv ***
// Watchdog that flags a clock level which has not changed for a given number of cycles.
`timescale 1ns/1ps
module lasi_clock_watch #(
    parameter int TIMEOUT = 1250
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkLevel,
    output logic lost
);
    localparam int CW = $clog2(TIMEOUT + 1);
    logic prevLevel_reg, prevLevel_next;
    logic [CW-1:0] idle_reg, idle_next;
    logic lost_reg, lost_next;

    always_comb
    begin
        prevLevel_next = clkLevel;
        if (clkLevel != prevLevel_reg)
            idle_next = '0;
        else if (idle_reg != CW'(TIMEOUT))
            idle_next = idle_reg + 1'b1;
        else
            idle_next = idle_reg;
        lost_next = (clkLevel == prevLevel_reg) && (idle_next == CW'(TIMEOUT));
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevLevel_reg <= 1'b0;
            idle_reg <= '0;
            lost_reg <= 1'b0;
        end
        else
        begin
            prevLevel_reg <= prevLevel_next;
            idle_reg <= idle_next;
            lost_reg <= lost_next;
        end
    end

    assign lost = lost_reg;
endmodule : lasi_clock_watch

// *** logic/lasi_line_alarm_status.sv ***
// Line alarm detectors, status and mask registers, and the active-low interrupt output.
`timescale 1ns/1ps
`include "lasi_defs.svh"
module lasi_line_alarm_status #(
    parameter int T1_WIN_CYCLES = `LASI_T1_WINDOW_US * `LASI_CLK_MHZ,
    parameter int TXCLK_CYCLES = (`LASI_TXCLK_LOSS_NS * `LASI_CLK_MHZ) / 1000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire lasi_pkg::lasi_mode_t lineMode,
    input wire logic rclLongThreshold,
    input wire logic rxBit,
    input wire logic rxBitValid,
    input wire logic loopUpSeen,
    input wire logic loopDownSeen,
    input wire logic patternLock,
    input wire logic txLineClock,
    input wire logic txCurrentLimitHit,
    input wire logic txOpenCircuit,
    output logic intOut_n,
    output logic txClockLost
);
    localparam int TW = $clog2(T1_WIN_CYCLES + 1);

    function automatic lasi_pkg::lasi_count_t lasiInc(input lasi_pkg::lasi_count_t v, input logic en);
        lasiInc = (en && v != 12'hFFF) ? v + 12'h001 : v;
    endfunction : lasiInc

    logic rstMeta_reg, rstSync_reg;
    logic rstSync_n;
    logic [2:0] pinSync;
    logic txClkLive;

    // Reset is released through two flops so every register leaves reset on the same edge.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end
    assign rstSync_n = rstSync_reg;

    lasi_pin_sync #(.WIDTH(3)) pinSyncInst (
        .clk(clk),
        .rst_n(rstSync_n),
        .pinIn({txLineClock, txCurrentLimitHit, txOpenCircuit}),
        .pinOut(pinSync)
    );

    lasi_clock_watch #(.TIMEOUT(TXCLK_CYCLES)) txClockWatch (
        .clk(clk),
        .rst_n(rstSync_n),
        .clkLevel(pinSync[2]),
        .lost(txClkLive)
    );

    // Unframed all-ones detector: E1 uses 512-bit blocks, T1 a fixed time window.
    lasi_pkg::lasi_count_t ua1Zeros_reg, ua1Zeros_next, ua1Bits_reg, ua1Bits_next, ua1ZerosNow;
    logic [TW-1:0] ua1Timer_reg, ua1Timer_next;
    logic ua1Alarm_reg, ua1Alarm_next;
    logic zeroIn, ua1End;

    always_comb
    begin
        zeroIn = rxBitValid && !rxBit;
        ua1ZerosNow = lasiInc(ua1Zeros_reg, zeroIn);
        ua1Alarm_next = ua1Alarm_reg;
        ua1Bits_next = ua1Bits_reg;
        ua1Timer_next = ua1Timer_reg;
        if (lineMode == lasi_pkg::LASI_T1)
        begin
            ua1End = ua1Timer_reg == TW'(T1_WIN_CYCLES - 1);
            ua1Timer_next = ua1End ? '0 : ua1Timer_reg + 1'b1;
            if (ua1End)
                ua1Alarm_next = ua1ZerosNow <= `LASI_T1_UA1_SET_MAX;
        end
        else
        begin
            ua1End = rxBitValid && (ua1Bits_reg == `LASI_E1_UA1_SPAN - 12'h001);
            ua1Bits_next = ua1End ? 12'h000 : lasiInc(ua1Bits_reg, rxBitValid);
            if (ua1End && ua1ZerosNow < `LASI_E1_UA1_ZEROS)
                ua1Alarm_next = 1'b1;
            else if (ua1End && ua1ZerosNow > `LASI_E1_UA1_ZEROS)
                ua1Alarm_next = 1'b0;
        end
        ua1Zeros_next = ua1End ? 12'h000 : ua1ZerosNow;
    end

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            ua1Zeros_reg <= 12'h000;
            ua1Bits_reg <= 12'h000;
            ua1Timer_reg <= '0;
            ua1Alarm_reg <= 1'b0;
        end
        else
        begin
            ua1Zeros_reg <= ua1Zeros_next;
            ua1Bits_reg <= ua1Bits_next;
            ua1Timer_reg <= ua1Timer_next;
            ua1Alarm_reg <= ua1Alarm_next;
        end
    end

    // Carrier loss: a run of zeros sets it; the clear window opens at the first one.
    lasi_pkg::lasi_count_t rclRun_reg, rclRun_next, rclWin_reg, rclWin_next, rclOnes_reg, rclOnes_next;
    lasi_pkg::lasi_count_t rclSetAt, rclSpan, rclNeed;
    logic rclAlarm_reg, rclAlarm_next, rclOpen_reg, rclOpen_next;

    always_comb
    begin
        if (lineMode == lasi_pkg::LASI_T1)
        begin
            rclSetAt = rclLongThreshold ? `LASI_T1_RCL_LONG : `LASI_T1_RCL_SHORT;
            rclSpan = `LASI_T1_RCL_SPAN;
            rclNeed = `LASI_T1_RCL_ONES;
        end
        else
        begin
            rclSetAt = rclLongThreshold ? `LASI_E1_RCL_LONG : `LASI_E1_RCL_SHORT;
            rclSpan = `LASI_E1_RCL_SPAN;
            rclNeed = `LASI_E1_RCL_ONES;
        end
        rclRun_next = rclRun_reg;
        rclWin_next = rclWin_reg;
        rclOnes_next = rclOnes_reg;
        rclAlarm_next = rclAlarm_reg;
        rclOpen_next = rclOpen_reg;
        if (rxBitValid)
        begin
            rclRun_next = rxBit ? 12'h000 : lasiInc(rclRun_reg, 1'b1);
            if (!rclAlarm_reg)
            begin
                rclOpen_next = 1'b0;
                rclAlarm_next = rclRun_next >= rclSetAt;
            end
            else if (!rclOpen_reg)
            begin
                rclOpen_next = rxBit;
                rclWin_next = 12'h001;
                rclOnes_next = 12'h001;
            end
            else
            begin
                rclWin_next = lasiInc(rclWin_reg, 1'b1);
                rclOnes_next = lasiInc(rclOnes_reg, rxBit);
                if (rclOnes_next >= rclNeed)
                begin
                    rclAlarm_next = 1'b0;
                    rclOpen_next = 1'b0;
                end
                else if (rclWin_next >= rclSpan)
                    rclOpen_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            rclRun_reg <= 12'h000;
            rclWin_reg <= 12'h000;
            rclOnes_reg <= 12'h000;
            rclAlarm_reg <= 1'b0;
            rclOpen_reg <= 1'b0;
        end
        else
        begin
            rclRun_reg <= rclRun_next;
            rclWin_reg <= rclWin_next;
            rclOnes_reg <= rclOnes_next;
            rclAlarm_reg <= rclAlarm_next;
            rclOpen_reg <= rclOpen_next;
        end
    end

    // Status, mask and interrupt state.
    lasi_pkg::lasi_byte_t live, statusNow, readClr, setEv;
    lasi_pkg::lasi_byte_t latch_reg, latch_next, view_reg, view_next, lastMask_reg, lastMask_next;
    lasi_pkg::lasi_byte_t mask_reg, mask_next, pend_reg, pend_next, prevLive_reg, prevStatus_reg;
    lasi_pkg::lasi_byte_t rdData_reg, rdData_next;
    logic srWrite, srRead, intOut_n_reg, intOut_n_next, txLost_reg;

    always_comb
    begin
        live = {loopUpSeen, loopDownSeen, txClkLive, ua1Alarm_reg, rclAlarm_reg, pinSync[1], pinSync[0], patternLock};
        statusNow = (latch_reg & `LASI_LATCHED_BITS) | (live & ~`LASI_LATCHED_BITS);
        srWrite = regWrite && regAddr == `LASI_ADDR_STATUS;
        srRead = regRead && regAddr == `LASI_ADDR_STATUS;
        // Only bits the host selected in its last status write are consumed by the read.
        readClr = srRead ? lastMask_reg : `LASI_READ_NONE;
        // A live condition re-sets its latch in the same cycle, so an event never loses to a read.
        latch_next = (latch_reg & ~(readClr & view_reg)) | (live & `LASI_LATCHED_BITS);
        view_next = srWrite ? ((regWrData & statusNow) | (~regWrData & view_reg)) : view_reg;
        lastMask_next = srWrite ? regWrData : lastMask_reg;
        mask_next = (regWrite && regAddr == `LASI_ADDR_MASK) ? regWrData : mask_reg;
        setEv = ((live ^ prevLive_reg) & `LASI_CHANGE_BITS)
            | (statusNow & ~prevStatus_reg & ~`LASI_CHANGE_BITS);
        pend_next = (pend_reg & ~readClr) | setEv;
        intOut_n_next = ~|(pend_next & mask_next);
        if (!regRead)
            rdData_next = rdData_reg;
        else if (regAddr == `LASI_ADDR_STATUS)
            rdData_next = view_reg;
        else if (regAddr == `LASI_ADDR_MASK)
            rdData_next = mask_reg;
        else
            rdData_next = `LASI_READ_NONE;
    end

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            latch_reg <= `LASI_STATUS_RESET;
            view_reg <= `LASI_STATUS_RESET;
            lastMask_reg <= `LASI_STATUS_RESET;
            mask_reg <= `LASI_MASK_RESET;
            pend_reg <= `LASI_STATUS_RESET;
            prevLive_reg <= `LASI_STATUS_RESET;
            prevStatus_reg <= `LASI_STATUS_RESET;
            rdData_reg <= `LASI_READ_NONE;
            intOut_n_reg <= 1'b1;
            txLost_reg <= 1'b0;
        end
        else
        begin
            latch_reg <= latch_next;
            view_reg <= view_next;
            lastMask_reg <= lastMask_next;
            mask_reg <= mask_next;
            pend_reg <= pend_next;
            prevLive_reg <= live;
            prevStatus_reg <= statusNow;
            rdData_reg <= rdData_next;
            intOut_n_reg <= intOut_n_next;
            txLost_reg <= txClkLive;
        end
    end

    assign regRdData = rdData_reg;
    assign intOut_n = intOut_n_reg;
    assign txClockLost = txLost_reg;

    default clocking lasiCb @(posedge clk);
    endclocking
    default disable iff (!rstSync_n);

    latchHold_a: assert property (latch_reg[7] && !srRead |=> latch_reg[7])
        else $error("latched loop-up bit dropped without a read");
    stickyKeep_a: assert property (srRead && rclAlarm_reg |=> latch_reg[`LASI_BIT_RCL])
        else $error("carrier loss bit cleared while alarm active");
    refreshHold_a: assert property (srWrite && !regWrData[0] |=> view_reg[0] == $past(view_reg[0]))
        else $error("unselected status bit changed on write");
    refreshTake_a: assert property (srWrite && regWrData[1] |=> view_reg[1] == $past(statusNow[1]))
        else $error("selected status bit not refreshed on write");
    maskBlock_a: assert property (mask_reg == 8'h00 && mask_next == 8'h00 |=> intOut_n)
        else $error("interrupt asserted while all sources masked");
    changeInt_a: assert property ($changed(rclAlarm_reg) && mask_reg[`LASI_BIT_RCL]
        && mask_next[`LASI_BIT_RCL] |=> !intOut_n)
        else $error("carrier loss change did not pull interrupt low");
    readRelease_a: assert property (srRead && lastMask_reg == 8'hFF && setEv == 8'h00 |=> intOut_n)
        else $error("interrupt not released after full read");
    setInt_a: assert property ($rose(statusNow[0]) && mask_reg[0] && mask_next[0] |=> !intOut_n)
        else $error("pattern lock set did not interrupt");
    ua1E1_a: assert property (lineMode == lasi_pkg::LASI_E1 && ua1End && ua1ZerosNow == 12'h000 |=> ua1Alarm_reg)
        else $error("E1 all-ones alarm not set on zero-free block");
    ua1T1_a: assert property (lineMode == lasi_pkg::LASI_T1 && ua1End && ua1ZerosNow >= 12'h006 |=> !ua1Alarm_reg)
        else $error("T1 all-ones alarm not cleared");
    rclE1_a: assert property (lineMode == lasi_pkg::LASI_E1 && !rclLongThreshold && zeroIn
        && rclRun_reg == 12'h0FE && !rclAlarm_reg |=> rclAlarm_reg)
        else $error("E1 carrier loss not set at 255 zeros");
    rclT1_a: assert property (lineMode == lasi_pkg::LASI_T1 && !rclLongThreshold && zeroIn
        && rclRun_reg < 12'h0BF && !rclAlarm_reg |=> !rclAlarm_reg)
        else $error("T1 carrier loss set before 192 zeros");
    txLost_a: assert property ($rose(txClkLive) |=> txClockLost && statusNow[`LASI_BIT_TXCLK])
        else $error("clock loss pin or status not raised");
    liveBits_a: assert property (statusNow[2:0] == {pinSync[1], pinSync[0], patternLock})
        else $error("real-time status bits do not follow sources");
    // Register access, the path of each latched source into its latch, and interrupt set and release.
    rdStatus_a: assert property (srRead |=> regRdData == $past(view_reg))
        else $error("status read did not return the snapshot");
    rdMask_a: assert property (regRead && regAddr == `LASI_ADDR_MASK |=> regRdData == $past(mask_reg))
        else $error("mask read did not return the mask");
    maskTake_a: assert property (regWrite && regAddr == `LASI_ADDR_MASK |=> mask_reg == $past(regWrData))
        else $error("mask write did not land");
    loopUpSet_a: assert property (loopUpSeen |=> latch_reg[7])
        else $error("loop-up latch not set");
    loopDownSet_a: assert property (loopDownSeen |=> latch_reg[6])
        else $error("loop-down latch not set");
    ua1Latch_a: assert property (ua1Alarm_reg |=> latch_reg[`LASI_BIT_UA1])
        else $error("all-ones latch not set");
    rclLatch_a: assert property (rclAlarm_reg |=> latch_reg[`LASI_BIT_RCL])
        else $error("carrier loss latch not set");
    readClear_a: assert property (srRead && lastMask_reg[7] && view_reg[7] && !loopUpSeen |=> !latch_reg[7])
        else $error("read loop-up latch not cleared");
    ua1Change_a: assert property ($changed(ua1Alarm_reg) && mask_reg[`LASI_BIT_UA1]
        && mask_next[`LASI_BIT_UA1] |=> !intOut_n)
        else $error("all-ones change did not interrupt");
    clkChange_a: assert property ($changed(txClkLive) && mask_reg[`LASI_BIT_TXCLK]
        && mask_next[`LASI_BIT_TXCLK] |=> !intOut_n)
        else $error("clock loss change did not interrupt");
    pendClear_a: assert property (srRead && lastMask_reg[`LASI_BIT_RCL] && !setEv[`LASI_BIT_RCL]
        |=> !pend_reg[`LASI_BIT_RCL])
        else $error("read did not release carrier loss interrupt");
    intLevel_a: assert property (intOut_n == !(|(pend_reg & mask_reg)))
        else $error("interrupt differs from pending enabled sources");
    ua1E1Clear_a: assert property (lineMode == lasi_pkg::LASI_E1 && ua1End && ua1ZerosNow > 12'h002
        |=> !ua1Alarm_reg)
        else $error("E1 all-ones alarm not cleared");
    ua1T1Set_a: assert property (lineMode == lasi_pkg::LASI_T1 && ua1End && ua1ZerosNow <= 12'h005
        |=> ua1Alarm_reg)
        else $error("T1 all-ones alarm not set");
    rclClear_a: assert property (rclAlarm_reg && rclOpen_reg && rxBitValid && rxBit
        && rclOnes_reg == rclNeed - 12'h001 |=> !rclAlarm_reg)
        else $error("carrier loss not cleared by enough ones");
    rclLong_a: assert property (lineMode == lasi_pkg::LASI_E1 && rclLongThreshold && zeroIn
        && rclRun_reg < 12'h7FF && !rclAlarm_reg |=> !rclAlarm_reg)
        else $error("E1 carrier loss set before 2048 zeros");
    txPin_a: assert property (txClockLost == $past(txClkLive))
        else $error("clock loss pin does not follow the watchdog");

    interruptSeen_c: cover property ($fell(intOut_n));
    readWriteBack_c: cover property (srWrite ##[1:4] srRead ##[1:4] srWrite);
    rclCycle_c: cover property ($rose(rclAlarm_reg) ##[1:1000] $fell(rclAlarm_reg));
    txLost_c: cover property ($rose(txClockLost));
    t1Carrier_c: cover property (lineMode == lasi_pkg::LASI_T1 && $rose(rclAlarm_reg));
endmodule : lasi_line_alarm_status

// *** testbench/lasi_host_model.sv ***
// Host model that reaches the status and mask registers over the parallel register port.
`timescale 1ns/1ps
`include "lasi_defs.svh"
module lasi_host_model (
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData
);
    initial
    begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = 8'h00;
    end

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        regAddr = addr;
        regWrData = data;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        // Idle lines are inverted so a design that samples them outside a strobe is caught.
        regAddr = ~addr;
        regWrData = ~data;
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        #1;
        regAddr = addr;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        regAddr = ~addr;
        @(posedge clk);
        #1;
        data = regRdData;
    endtask : rd

    task automatic poll(input logic [7:0] mask, output logic [7:0] data);
        wr(`LASI_ADDR_STATUS, mask);
        rd(`LASI_ADDR_STATUS, data);
        wr(`LASI_ADDR_STATUS, data & mask);
    endtask : poll
endmodule : lasi_host_model

// *** testbench/lasi_line_alarm_status_bench.sv ***
// Self-checking bench of the line alarm status block driven by a host model.
`timescale 1ns/1ps
`include "lasi_defs.svh"
module lasi_line_alarm_status_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr;
    logic regWrite;
    logic regRead;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    lasi_pkg::lasi_mode_t lineMode = lasi_pkg::LASI_E1;
    logic rclLongThreshold = 1'b0;
    logic rxBit = 1'b0;
    logic rxBitValid = 1'b0;
    logic loopUpSeen = 1'b0;
    logic loopDownSeen = 1'b0;
    logic patternLock = 1'b0;
    logic txLineClock = 1'b0;
    logic txCurrentLimitHit = 1'b0;
    logic txOpenCircuit = 1'b0;
    logic intOut_n;
    logic txClockLost;
    logic txRun = 1'b1;
    logic [1:0] txDiv = 2'h0;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 32'h6185;
    int k;
    lasi_pkg::lasi_byte_t rdVal;
    lasi_pkg::lasi_byte_t expVal;

    always #2 clk = ~clk;

    // The transmit clock toggles every fourth cycle so the pin synchroniser always settles.
    always @(posedge clk)
    begin
        txDiv <= txDiv + 2'h1;
        if (txRun && txDiv == 2'h3)
        begin
            txLineClock <= #1 ~txLineClock;
        end
    end

    lasi_line_alarm_status #(.T1_WIN_CYCLES(200), .TXCLK_CYCLES(20)) lasi_line_alarm_status_inst (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .regRdData(regRdData), .lineMode(lineMode),
        .rclLongThreshold(rclLongThreshold), .rxBit(rxBit), .rxBitValid(rxBitValid),
        .loopUpSeen(loopUpSeen), .loopDownSeen(loopDownSeen), .patternLock(patternLock),
        .txLineClock(txLineClock), .txCurrentLimitHit(txCurrentLimitHit), .txOpenCircuit(txOpenCircuit),
        .intOut_n(intOut_n), .txClockLost(txClockLost));

    lasi_host_model lasi_host_model_inst (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData));

    function automatic lasi_pkg::lasi_byte_t rt_expect(input logic [2:0] pins);
        return {5'h00, pins[2], pins[1], pins[0]};
    endfunction : rt_expect

    task automatic check(input lasi_pkg::lasi_byte_t seen, input lasi_pkg::lasi_byte_t exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic wait_sig(input logic useLost, input logic lvl);
        int i;
        logic s;
        s = useLost ? txClockLost : intOut_n;
        for (i = 0; i < 200 && s !== lvl; i++)
        begin
            @(posedge clk);
            #1;
            s = useLost ? txClockLost : intOut_n;
        end
        check({7'h00, s}, {7'h00, lvl});
        if (s !== lvl)
        begin
            finish_test();
        end
    endtask : wait_sig

    task automatic send(input logic b, input int n);
        int i;
        for (i = 0; i < n; i++)
        begin
            @(posedge clk);
            #1;
            rxBit = b;
            rxBitValid = 1'b1;
            @(posedge clk);
            #1;
            rxBitValid = 1'b0;
        end
    endtask : send

    task automatic set_pins(input logic [2:0] v);
        @(posedge clk);
        #1;
        {txCurrentLimitHit, txOpenCircuit, patternLock} = v;
    endtask : set_pins

    task automatic set_mask(input lasi_pkg::lasi_byte_t m);
        // Reading everything first drops pending events left by earlier traffic.
        lasi_host_model_inst.poll(8'hFF, rdVal);
        lasi_host_model_inst.wr(`LASI_ADDR_MASK, m);
    endtask : set_mask

    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({6'h00, intOut_n, txClockLost}, 8'h02);
        lasi_host_model_inst.rd(`LASI_ADDR_MASK, rdVal);
        check(rdVal, `LASI_MASK_RESET);
        for (k = 0; k < 4; k++)
        begin
            expVal = lasi_pkg::lasi_byte_t'($random(seed));
            lasi_host_model_inst.wr(`LASI_ADDR_MASK, expVal);
            lasi_host_model_inst.rd(`LASI_ADDR_MASK, rdVal);
            check(rdVal, expVal);
            lasi_host_model_inst.rd(8'h08, rdVal);
            check(rdVal, `LASI_READ_NONE);
        end
        set_mask(8'h00);
        @(posedge clk);
        #1;
        loopUpSeen = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        loopUpSeen = 1'b0;
        lasi_host_model_inst.poll(8'h40, rdVal);
        check(rdVal, 8'h00);
        lasi_host_model_inst.poll(8'h80, rdVal);
        check(rdVal, 8'h80);
        lasi_host_model_inst.poll(8'h80, rdVal);
        check(rdVal, 8'h00);
        @(posedge clk);
        #1;
        loopDownSeen = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        loopDownSeen = 1'b0;
        lasi_host_model_inst.poll(8'hC0, rdVal);
        check(rdVal, 8'h40);
        for (k = 0; k < 5; k++)
        begin
            expVal = (k == 4) ? 8'h07 : rt_expect(3'($random(seed)));
            set_pins(expVal[2:0]);
            repeat (8) @(posedge clk);
            lasi_host_model_inst.poll(8'h07, rdVal);
            check(rdVal & 8'h04, expVal & 8'h04);
            check(rdVal & 8'h02, expVal & 8'h02);
            check(rdVal & 8'h01, expVal & 8'h01);
            check({7'h00, intOut_n}, 8'h01);
        end
        set_pins(3'h0);
        set_mask(8'h01);
        set_pins(3'h1);
        wait_sig(1'b0, 1'b0);
        lasi_host_model_inst.poll(8'h01, rdVal);
        check(rdVal, 8'h01);
        wait_sig(1'b0, 1'b1);
        set_pins(3'h0);
        set_mask(8'h00);
        set_pins(3'h1);
        repeat (12) @(posedge clk);
        #1;
        check({7'h00, intOut_n}, 8'h01);
        lasi_host_model_inst.wr(`LASI_ADDR_MASK, 8'h01);
        wait_sig(1'b0, 1'b0);
        lasi_host_model_inst.poll(8'h01, rdVal);
        wait_sig(1'b0, 1'b1);
        set_pins(3'h0);
        set_mask(8'h20);
        txRun = 1'b0;
        wait_sig(1'b1, 1'b1);
        wait_sig(1'b0, 1'b0);
        lasi_host_model_inst.poll(8'h20, rdVal);
        check(rdVal, 8'h20);
        wait_sig(1'b0, 1'b1);
        txRun = 1'b1;
        wait_sig(1'b1, 1'b0);
        wait_sig(1'b0, 1'b0);
        lasi_host_model_inst.poll(8'h20, rdVal);
        check(rdVal, 8'h00);
        wait_sig(1'b0, 1'b1);
        set_mask(8'h08);
        send(1'b0, 254);
        lasi_host_model_inst.poll(8'h08, rdVal);
        check(rdVal, 8'h00);
        send(1'b0, 1);
        wait_sig(1'b0, 1'b0);
        lasi_host_model_inst.poll(8'h08, rdVal);
        check(rdVal, 8'h08);
        wait_sig(1'b0, 1'b1);
        lasi_host_model_inst.poll(8'h08, rdVal);
        check(rdVal, 8'h08);
        send(1'b1, 1100);
        wait_sig(1'b0, 1'b0);
        lasi_host_model_inst.poll(8'h18, rdVal);
        check(rdVal, 8'h18);
        lasi_host_model_inst.poll(8'h18, rdVal);
        check(rdVal, 8'h10);
        wait_sig(1'b0, 1'b1);
        // T1 operation: time-window all-ones and the 192 and 1544 zero carrier thresholds.
        lineMode = lasi_pkg::LASI_T1;
        send(1'b0, 191);
        lasi_host_model_inst.poll(8'h18, rdVal);
        check(rdVal, 8'h10);
        lasi_host_model_inst.poll(8'h10, rdVal);
        check(rdVal, 8'h00);
        send(1'b0, 1);
        wait_sig(1'b0, 1'b0);
        send(1'b1, 13);
        lasi_host_model_inst.poll(8'h08, rdVal);
        check(rdVal, 8'h08);
        lasi_host_model_inst.poll(8'h08, rdVal);
        check(rdVal, 8'h08);
        send(1'b1, 1);
        lasi_host_model_inst.poll(8'h08, rdVal);
        check(rdVal, 8'h08);
        lasi_host_model_inst.poll(8'h08, rdVal);
        check(rdVal, 8'h00);
        repeat (450) @(posedge clk);
        #1;
        lasi_host_model_inst.poll(8'h10, rdVal);
        check(rdVal, 8'h10);
        rclLongThreshold = 1'b1;
        send(1'b0, 1543);
        lasi_host_model_inst.poll(8'h08, rdVal);
        check(rdVal & 8'h08, 8'h00);
        send(1'b0, 1);
        lasi_host_model_inst.poll(8'h08, rdVal);
        check(rdVal & 8'h08, 8'h08);
        finish_test();
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
endmodule : lasi_line_alarm_status_bench
